// ==== logic/emsd_pkg.sv ====
// Package of constants and carrier types for the external memory select decoder.
package emsd_pkg;

    // ==========================================================
    // Widths and address map
    localparam int ADDR_W = 14;
    localparam int DATA_W = 24;
    localparam int WAIT_W = 3;
    localparam int PAGE_W = 8;
    localparam int IO_REGIONS = 4;
    localparam int OVL_W = 4;
    localparam logic [ADDR_W-1:0] PM_WIN_LO = 14'h2000;
    localparam int BANK_BIT = 13;
    localparam int IO_ADDR_W = 11;
    localparam int IO_REGION_LSB = 9;
    localparam int BYTE_DATA_LSB = 8;
    localparam int BYTE_PAGE_LSB = 16;
    localparam logic [OVL_W-1:0] OVL_EXT1 = 4'h1;
    localparam logic [OVL_W-1:0] OVL_EXT2 = 4'h2;

    // ==========================================================
    // Access kinds and carriers
    typedef enum logic [1:0] {
        EMSD_PM = 2'h0,
        EMSD_DM = 2'h1,
        EMSD_BM = 2'h2,
        EMSD_IO = 2'h3
    } emsd_kind_t;

    typedef struct packed {
        logic pm;
        logic dm;
        logic bm;
        logic io;
    } emsd_sel_t;

    typedef struct packed {
        logic                valid;
        emsd_kind_t          kind;
        logic                fetch;
        logic                write;
        logic [ADDR_W-1:0]   addr;
        logic [PAGE_W-1:0]   page;
        logic [DATA_W-1:0]   wdata;
    } emsd_req_t;

    typedef struct packed {
        logic                ack;
        logic                err;
        logic [DATA_W-1:0]   rdata;
    } emsd_resp_t;

    localparam emsd_sel_t CMS_EN_RESET = '{pm: 1'b1, dm: 1'b1, bm: 1'b0,
                                           io: 1'b1};
    localparam logic BMS_EN_RESET = 1'b1;

endpackage

// ==== logic/emsd_sync.sv ====
// Two-stage synchroniser for pins entering the processor clock domain.
`timescale 1ns/1ps
`default_nettype none

module emsd_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    // ==========================================================
    // Per-bit flip-flop pair
    // The first stage feeds only the second, so metastability has a full
    // cycle to settle before any logic sees the value.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta_reg;
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    meta_reg    <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    meta_reg    <= async_in[i];
                    sync_out[i] <= meta_reg;
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// ==== logic/emsd_decode.sv ====
// Top level of the external memory select decoder with wait-state sequencing.
`timescale 1ns/1ps
`default_nettype none

module emsd_decode (
    input  wire logic                                     clock,
    input  wire logic                                     rst,
    input  wire emsd_pkg::emsd_req_t                      core_req,
    output logic                                          core_ready,
    output emsd_pkg::emsd_resp_t                          core_resp,
    input  wire logic                                     host_mode,
    input  wire logic [emsd_pkg::OVL_W-1:0]               program_overlay_select,
    input  wire logic [emsd_pkg::OVL_W-1:0]               data_overlay_select,
    input  wire logic [emsd_pkg::WAIT_W-1:0]              program_wait_count,
    input  wire logic [emsd_pkg::WAIT_W-1:0]              data_wait_count,
    input  wire logic [emsd_pkg::WAIT_W-1:0]              byte_wait_count,
    input  wire logic [emsd_pkg::IO_REGIONS-1:0][emsd_pkg::WAIT_W-1:0] io_region_wait_counts,
    input  wire logic                                     cfg_we,
    input  wire emsd_pkg::emsd_sel_t                      cfg_combined_select_enables,
    input  wire logic                                     cfg_byte_select_enable,
    output emsd_pkg::emsd_sel_t                           combined_select_enables,
    output logic                                          byte_select_enable,
    input  wire logic                                     bus_grant,
    input  wire logic [emsd_pkg::DATA_W-1:0]              ext_data_in,
    output logic [emsd_pkg::DATA_W-1:0]                   ext_data_out,
    output logic                                          ext_data_oe_n,
    output logic [emsd_pkg::ADDR_W-1:0]                   ext_addr,
    output logic                                          ext_rd_n,
    output logic                                          ext_wr_n,
    output logic                                          program_memory_select_n,
    output logic                                          data_memory_select_n,
    output logic                                          byte_memory_select_n,
    output logic                                          io_memory_select_n,
    output logic                                          combined_memory_select_n
);

    // ==========================================================
    // State
    typedef enum logic [1:0] {
        EMSD_ST_IDLE   = 2'b01,
        EMSD_ST_ACCESS = 2'b10
    } emsd_st_t;

    typedef struct packed {
        emsd_st_t                        fsm;
        logic [emsd_pkg::WAIT_W-1:0]     count;
        logic [emsd_pkg::ADDR_W-1:0]     addr;
        emsd_pkg::emsd_sel_t             sel;
        logic                            write;
        logic [emsd_pkg::DATA_W-1:0]     dout;
        logic [emsd_pkg::DATA_W-1:0]     rdata;
        logic                            ack;
        logic                            err;
        emsd_pkg::emsd_sel_t             cms_en;
        logic                            bms_en;
    } emsd_state_t;

    emsd_state_t state_reg;
    emsd_state_t state_next;

    // ==========================================================
    // Pin synchronisers
    // Read data passes two stages too, so a read takes the pins as they stood
    // two edges before the select ends; reads need two wait states or more.
    logic [emsd_pkg::DATA_W-1:0] din_sync;
    logic                        grant_sync;

    emsd_sync #(
        .WIDTH(emsd_pkg::DATA_W + 1)
    ) u_sync (
        .clock    (clock),
        .rst      (rst),
        .async_in ({bus_grant, ext_data_in}),
        .sync_out ({grant_sync, din_sync})
    );

    // ==========================================================
    // Request decode
    logic                        take;
    logic                        pm_ext;
    logic                        dm_ext;
    logic                        is_ext;
    logic                        fetch_refused;
    logic [emsd_pkg::WAIT_W-1:0] wait_sel;
    logic [emsd_pkg::WAIT_W-1:0] io_wait_sel;
    logic [emsd_pkg::ADDR_W-1:0] addr_sel;
    logic [emsd_pkg::DATA_W-1:0] dout_sel;
    logic                        bank_sel;
    emsd_pkg::emsd_sel_t         sel_sel;

    assign core_ready = state_reg.fsm == EMSD_ST_IDLE && !grant_sync;
    assign take = core_req.valid && core_ready;

    always_comb begin
        pm_ext = core_req.addr >= emsd_pkg::PM_WIN_LO &&
                 (program_overlay_select == emsd_pkg::OVL_EXT1 ||
                  program_overlay_select == emsd_pkg::OVL_EXT2);
        dm_ext = core_req.addr < emsd_pkg::PM_WIN_LO &&
                 (data_overlay_select == emsd_pkg::OVL_EXT1 ||
                  data_overlay_select == emsd_pkg::OVL_EXT2);
        fetch_refused = host_mode && core_req.fetch &&
                        core_req.kind == emsd_pkg::EMSD_PM && pm_ext;
        io_wait_sel = io_region_wait_counts[
            core_req.addr[emsd_pkg::IO_REGION_LSB +: 2]];
        bank_sel = 1'b0;
        sel_sel = '0;
        wait_sel = '0;
        addr_sel = core_req.addr;
        dout_sel = core_req.wdata;
        unique case (core_req.kind)
            emsd_pkg::EMSD_PM: begin
                sel_sel.pm = pm_ext && !fetch_refused;
                wait_sel = program_wait_count;
                bank_sel = program_overlay_select == emsd_pkg::OVL_EXT2;
            end
            emsd_pkg::EMSD_DM: begin
                sel_sel.dm = dm_ext;
                wait_sel = data_wait_count;
                bank_sel = data_overlay_select == emsd_pkg::OVL_EXT2;
            end
            emsd_pkg::EMSD_BM: begin
                sel_sel.bm = 1'b1;
                wait_sel = byte_wait_count;
                dout_sel = '0;
                dout_sel[emsd_pkg::BYTE_PAGE_LSB +: emsd_pkg::PAGE_W] =
                    core_req.page;
                dout_sel[emsd_pkg::BYTE_DATA_LSB +: 8] =
                    core_req.wdata[7:0];
            end
            emsd_pkg::EMSD_IO: begin
                sel_sel.io = 1'b1;
                wait_sel = io_wait_sel;
                addr_sel = '0;
                addr_sel[emsd_pkg::IO_ADDR_W-1:0] =
                    core_req.addr[emsd_pkg::IO_ADDR_W-1:0];
            end
        endcase
        if (sel_sel.pm || sel_sel.dm) begin
            addr_sel[emsd_pkg::BANK_BIT] = bank_sel;
        end
        if (host_mode) begin
            // Only the lowest line leaves the chip; the rest reads zero.
            addr_sel = {{(emsd_pkg::ADDR_W-1){1'b0}}, core_req.addr[0]};
        end
        is_ext = sel_sel != '0;
    end

    // ==========================================================
    // Next state
    always_comb begin
        state_next = state_reg;
        state_next.ack = 1'b0;
        state_next.err = 1'b0;
        if (cfg_we) begin
            state_next.cms_en = cfg_combined_select_enables;
            state_next.bms_en = cfg_byte_select_enable;
        end
        unique case (state_reg.fsm)
            EMSD_ST_IDLE: begin
                if (take && !is_ext) begin
                    // On-chip access or refused fetch: answered next cycle.
                    state_next.ack = 1'b1;
                    state_next.err = fetch_refused;
                end else if (take) begin
                    state_next.fsm   = EMSD_ST_ACCESS;
                    state_next.count = wait_sel;
                    state_next.addr  = addr_sel;
                    state_next.sel   = sel_sel;
                    state_next.write = core_req.write;
                    state_next.dout  = dout_sel;
                end
            end
            EMSD_ST_ACCESS: begin
                if (state_reg.count == '0) begin
                    state_next.fsm   = EMSD_ST_IDLE;
                    state_next.sel   = '0;
                    state_next.ack   = 1'b1;
                    state_next.rdata = din_sync;
                    if (state_reg.sel.bm) begin
                        state_next.rdata = '0;
                        state_next.rdata[7:0] =
                            din_sync[emsd_pkg::BYTE_DATA_LSB +: 8];
                    end
                end else begin
                    state_next.count = state_reg.count - 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg.fsm    <= EMSD_ST_IDLE;
            state_reg.count  <= '0;
            state_reg.addr   <= '0;
            state_reg.sel    <= '0;
            state_reg.write  <= 1'b0;
            state_reg.dout   <= '0;
            state_reg.rdata  <= '0;
            state_reg.ack    <= 1'b0;
            state_reg.err    <= 1'b0;
            state_reg.cms_en <= emsd_pkg::CMS_EN_RESET;
            state_reg.bms_en <= emsd_pkg::BMS_EN_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // Outputs
    logic access;

    assign access = state_reg.fsm == EMSD_ST_ACCESS;
    assign core_resp.ack = state_reg.ack;
    assign core_resp.err = state_reg.err;
    assign core_resp.rdata = state_reg.rdata;
    assign combined_select_enables = state_reg.cms_en;
    assign byte_select_enable = state_reg.bms_en;
    assign ext_addr = state_reg.addr;
    assign ext_data_out = state_reg.dout;
    assign ext_data_oe_n = !(access && state_reg.write);
    assign ext_rd_n = !(access && !state_reg.write);
    assign ext_wr_n = !(access && state_reg.write);
    assign program_memory_select_n = !state_reg.sel.pm;
    assign data_memory_select_n = !state_reg.sel.dm;
    assign io_memory_select_n = !state_reg.sel.io;
    assign byte_memory_select_n = !(state_reg.sel.bm && state_reg.bms_en);
    // Built from the same select flops, so it switches in the same cycle.
    assign combined_memory_select_n =
        !(|(state_reg.sel & state_reg.cms_en));

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_internal_one_cycle: assert property (
        take && !is_ext |=> core_resp.ack && state_reg.fsm == EMSD_ST_IDLE
    ) else $error("On-chip access not answered in one cycle.");

    a_wait_countdown: assert property (
        access && state_reg.count != '0 |=>
            access && state_reg.count == $past(state_reg.count) - 1'b1
    ) else $error("Wait count did not step down by one.");

    a_io_region_wait: assert property (
        take && core_req.kind == emsd_pkg::EMSD_IO |=>
            state_reg.count == $past(io_wait_sel) && !io_memory_select_n
    ) else $error("I/O wait count not taken from its region.");

    a_io_upper_zero: assert property (
        !io_memory_select_n |->
            ext_addr[emsd_pkg::ADDR_W-1:emsd_pkg::IO_ADDR_W] == '0
    ) else $error("I/O access drove upper address lines.");

    a_overlay_bank: assert property (
        take && sel_sel.pm && !host_mode |=>
            ext_addr[emsd_pkg::BANK_BIT] == $past(bank_sel)
    ) else $error("Program overlay bank bit wrong.");

    a_host_fetch: assert property (
        take && fetch_refused |=> core_resp.err && program_memory_select_n
    ) else $error("Host-mode external fetch was not refused.");

    a_combined_follow: assert property (
        !data_memory_select_n && state_reg.cms_en.dm |->
            !combined_memory_select_n
    ) else $error("Combined select missed an enabled data select.");

    a_byte_disabled: assert property (
        !state_reg.bms_en |-> byte_memory_select_n
    ) else $error("Disabled byte select went active.");

    a_grant_release: assert property (
        grant_sync && !access |=> combined_memory_select_n && !access
    ) else $error("Access started while bus granted away.");

    a_selects_idle: assert property (
        !access |-> program_memory_select_n && data_memory_select_n &&
            io_memory_select_n && byte_memory_select_n
    ) else $error("Select active with no external access.");

    a_byte_page: assert property (
        take && core_req.kind == emsd_pkg::EMSD_BM |=>
            ext_data_out[emsd_pkg::BYTE_PAGE_LSB +: emsd_pkg::PAGE_W] ==
            $past(core_req.page)
    ) else $error("Byte page not on upper data lines.");

    a_byte_data: assert property (
        take && core_req.kind == emsd_pkg::EMSD_BM |=>
            ext_data_out[emsd_pkg::BYTE_DATA_LSB +: 8] ==
            $past(core_req.wdata[7:0])
    ) else $error("Byte write data not on middle data lines.");

    a_data_bank: assert property (
        take && sel_sel.dm && !host_mode |=>
            ext_addr[emsd_pkg::BANK_BIT] ==
            ($past(data_overlay_select) == emsd_pkg::OVL_EXT2)
    ) else $error("Data overlay bank bit wrong.");

    a_data_low_bits: assert property (
        take && sel_sel.dm && !host_mode |=>
            ext_addr[emsd_pkg::BANK_BIT-1:0] ==
            $past(core_req.addr[emsd_pkg::BANK_BIT-1:0])
    ) else $error("Data overlay low address bits wrong.");

    a_io_low_bits: assert property (
        take && core_req.kind == emsd_pkg::EMSD_IO && !host_mode |=>
            ext_addr[emsd_pkg::IO_ADDR_W-1:0] ==
            $past(core_req.addr[emsd_pkg::IO_ADDR_W-1:0])
    ) else $error("I/O address not on the low lines.");

    a_host_one_line: assert property (
        take && is_ext && host_mode |=>
            ext_addr[emsd_pkg::ADDR_W-1:1] == '0 &&
            ext_addr[0] == $past(core_req.addr[0])
    ) else $error("Host mode drove more than the lowest line.");

    a_data_wait: assert property (
        take && sel_sel.dm |=> state_reg.count == $past(data_wait_count)
    ) else $error("Data access did not load its wait count.");

    a_wait_end: assert property (
        access && state_reg.count == '0 |=> core_resp.ack && !access
    ) else $error("Access did not end when its wait count ran out.");

    a_combined_program: assert property (
        !program_memory_select_n && state_reg.cms_en.pm |->
            !combined_memory_select_n
    ) else $error("Combined select missed an enabled program select.");

    a_combined_byte: assert property (
        state_reg.sel.bm && state_reg.cms_en.bm |-> !combined_memory_select_n
    ) else $error("Combined select missed an enabled byte access.");

    a_combined_only: assert property (
        !combined_memory_select_n |->
            (!program_memory_select_n && state_reg.cms_en.pm) ||
            (!data_memory_select_n && state_reg.cms_en.dm) ||
            (!io_memory_select_n && state_reg.cms_en.io) ||
            (state_reg.sel.bm && state_reg.cms_en.bm)
    ) else $error("Combined select active with no enabled select.");

    a_enable_load: assert property (
        cfg_we |=> combined_select_enables ==
            $past(cfg_combined_select_enables) &&
            byte_select_enable == $past(cfg_byte_select_enable)
    ) else $error("Select enables not loaded by the write strobe.");

    a_byte_select_on: assert property (
        state_reg.sel.bm && state_reg.bms_en |-> !byte_memory_select_n
    ) else $error("Enabled byte select stayed inactive.");

endmodule

`default_nettype wire

// ==== tb/emsd_ext_mem.sv ====
// Behavioural model of the external memory on the parallel bus.
`timescale 1ns/1ps
`default_nettype none

module emsd_ext_mem (
    input  wire logic        clock,
    input  wire logic        chip_select_n,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [13:0] addr,
    input  wire logic [23:0] wdata,
    output var  logic [23:0] rdata
);
    logic [23:0] mem [0:16383];
    logic [23:0] last_q = 24'h000000;
    logic        drive;

    // A released bus shows the inverse of the last word, so stale data
    // cannot pass for a fresh read.
    assign drive = !chip_select_n && !rd_n;
    assign rdata = drive ? mem[addr] : ~last_q;

    always @(posedge clock) begin
        if (drive) begin
            last_q <= mem[addr];
        end
        if (!chip_select_n && !wr_n) begin
            mem[addr] <= wdata;
        end
    end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking testbench for the external memory select decoder.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    typedef struct packed {
        emsd_pkg::emsd_kind_t kind;
        logic                 wr;
        logic [13:0]          addr;
        logic [3:0]           ovl;
        logic [13:0]          xaddr;
        emsd_pkg::emsd_sel_t  sel;
        logic [3:0]           lat;
    } emsd_row_t;

    // ==========================================================
    // Signals
    logic                 clock = 1'b0;
    logic                 rst = 1'b1;
    emsd_pkg::emsd_req_t  req = '0;
    emsd_pkg::emsd_resp_t resp;
    logic                 core_ready;
    logic                 host_mode = 1'b0;
    logic [3:0]           ovl = 4'h0;
    logic [3:0][2:0]      io_w = {3'h7, 3'h0, 3'h5, 3'h1};
    logic                 cfg_we = 1'b0;
    emsd_pkg::emsd_sel_t  cfg_en = 4'hd;
    logic                 cfg_ben = 1'b1;
    emsd_pkg::emsd_sel_t  en_rb;
    logic                 ben_rb;
    logic                 grant = 1'b0;
    logic [2:0]           dw = 3'h1;
    logic                 oe_n;
    logic [23:0]          din;
    logic [23:0]          dout;
    logic [13:0]          xa;
    logic                 rd_n;
    logic                 wr_n;
    logic                 pm_n;
    logic                 dm_n;
    logic                 bm_n;
    logic                 io_n;
    logic                 cms_n;
    emsd_pkg::emsd_sel_t  exp_en = 4'hd;
    emsd_pkg::emsd_sel_t  seen;
    logic [2:0]           sseen;
    logic [13:0]          xseen;
    logic [23:0]          dseen;
    logic [4:0]           idle;
    logic                 err;
    int                   lat;
    int                   bad;
    int                   errors = 0;
    int                   n_tests = 0;
    emsd_row_t            rows [13];

    always #25 clock = ~clock;

    emsd_decode dut (
        .clock(clock), .rst(rst), .core_req(req), .core_ready(core_ready),
        .core_resp(resp), .host_mode(host_mode),
        .program_overlay_select(ovl), .data_overlay_select(ovl),
        .program_wait_count(3'h2), .data_wait_count(dw),
        .byte_wait_count(3'h3), .io_region_wait_counts(io_w),
        .cfg_we(cfg_we), .cfg_combined_select_enables(cfg_en),
        .cfg_byte_select_enable(cfg_ben), .combined_select_enables(en_rb),
        .byte_select_enable(ben_rb), .bus_grant(grant), .ext_data_in(din),
        .ext_data_out(dout), .ext_data_oe_n(oe_n), .ext_addr(xa),
        .ext_rd_n(rd_n), .ext_wr_n(wr_n), .program_memory_select_n(pm_n),
        .data_memory_select_n(dm_n), .byte_memory_select_n(bm_n),
        .io_memory_select_n(io_n), .combined_memory_select_n(cms_n));

    emsd_ext_mem mem (
        .clock(clock), .chip_select_n(&{pm_n, dm_n, bm_n, io_n, cms_n}),
        .rd_n(rd_n), .wr_n(wr_n), .addr(xa), .wdata(dout), .rdata(din));

    // ==========================================================
    // Tasks
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // One access; the combined select is judged in every cycle because it
    // must share the timing of the individual select it follows.
    task automatic go(input emsd_pkg::emsd_kind_t k, input logic w,
                      input logic [13:0] a, input logic ext);
        int n;
        req.kind = k;
        req.write = w;
        req.addr = a;
        req.valid = 1'b1;
        n = 0;
        while (core_ready !== 1'b1 && n < 50) begin
            @(negedge clock);
            n++;
        end
        if (core_ready !== 1'b1) errors++;
        @(negedge clock);
        req.valid = 1'b0;
        seen = '0;
        sseen = 3'h0;
        bad = 0;
        lat = 1;
        while (resp.ack !== 1'b1 && lat < 20) begin
            seen = seen | ~{pm_n, dm_n, bm_n, io_n};
            sseen = sseen | ~{oe_n, rd_n, wr_n};
            if (cms_n !== ~(ext & exp_en[3 - int'(k)])) bad++;
            xseen = xa;
            dseen = dout;
            @(negedge clock);
            lat++;
        end
        if (resp.ack !== 1'b1) errors++;
        err = resp.err;
        idle = {pm_n, dm_n, bm_n, io_n, cms_n};
        @(negedge clock);
    endtask

    // ==========================================================
    // Sequence
    initial begin
        rows[0]  = '{emsd_pkg::EMSD_PM, 0, 14'h2100, 0, 0, 4'h0, 1};
        rows[1]  = '{emsd_pkg::EMSD_PM, 0, 14'h2abc, 1, 14'h0abc, 4'h8, 4};
        rows[2]  = '{emsd_pkg::EMSD_PM, 1, 14'h3fff, 2, 14'h3fff, 4'h8, 4};
        rows[3]  = '{emsd_pkg::EMSD_PM, 0, 14'h1000, 2, 0, 4'h0, 1};
        rows[4]  = '{emsd_pkg::EMSD_DM, 0, 14'h1fff, 2, 14'h3fff, 4'h4, 3};
        rows[5]  = '{emsd_pkg::EMSD_DM, 1, 14'h0000, 1, 14'h0000, 4'h4, 3};
        rows[6]  = '{emsd_pkg::EMSD_DM, 0, 14'h2000, 1, 0, 4'h0, 1};
        rows[7]  = '{emsd_pkg::EMSD_DM, 0, 14'h0800, 3, 0, 4'h0, 1};
        rows[8]  = '{emsd_pkg::EMSD_IO, 0, 14'h01ff, 0, 14'h01ff, 4'h1, 3};
        rows[9]  = '{emsd_pkg::EMSD_IO, 1, 14'h3a00, 0, 14'h0200, 4'h1, 7};
        rows[10] = '{emsd_pkg::EMSD_IO, 0, 14'h05ff, 0, 14'h05ff, 4'h1, 2};
        rows[11] = '{emsd_pkg::EMSD_IO, 1, 14'h0600, 0, 14'h0600, 4'h1, 9};
        rows[12] = '{emsd_pkg::EMSD_BM, 0, 14'h1234, 0, 14'h1234, 4'h2, 5};
        repeat (12) @(negedge clock);
        rst = 1'b0;
        chk(24'({pm_n, dm_n, bm_n, io_n, cms_n}), 24'h1f);
        chk(24'(en_rb), 24'h00000d);
        chk(24'(ben_rb), 24'h1);
        $display("test reset done");
        foreach (rows[i]) begin
            ovl = rows[i].ovl;
            go(rows[i].kind, rows[i].wr, rows[i].addr, |rows[i].sel);
            chk(24'(lat), 24'(rows[i].lat));
            chk(24'(seen), 24'(rows[i].sel));
            chk(24'(bad), 24'h0);
            chk(24'(idle), 24'h1f);
            chk(24'(sseen), |rows[i].sel ? 24'(rows[i].wr ? 5 : 2) : 0);
            if (|rows[i].sel) chk(24'(xseen), 24'(rows[i].xaddr));
        end
        $display("test table done");
        ovl = 4'h1;
        req.wdata = 24'h00beef;
        go(emsd_pkg::EMSD_DM, 1'b1, 14'h0123, 1'b1);
        dw = 3'h2;
        go(emsd_pkg::EMSD_DM, 1'b0, 14'h0123, 1'b1);
        chk(24'(resp.rdata[15:0]), 24'h00beef);
        dw = 3'h1;
        req.page = 8'h5a;
        req.wdata = 24'h00003c;
        go(emsd_pkg::EMSD_BM, 1'b1, 14'h0042, 1'b1);
        chk(24'(dseen[23:8]), 24'h005a3c);
        $display("test round trip done");
        cfg_en = 4'h2;
        cfg_ben = 1'b0;
        cfg_we = 1'b1;
        @(negedge clock);
        cfg_we = 1'b0;
        exp_en = 4'h2;
        chk(24'({en_rb, ben_rb}), 24'h04);
        go(emsd_pkg::EMSD_BM, 1'b0, 14'h0042, 1'b1);
        chk(24'(seen), 24'h0);
        chk(24'(bad), 24'h0);
        chk(resp.rdata, 24'h00003c);
        go(emsd_pkg::EMSD_DM, 1'b0, 14'h0123, 1'b1);
        chk(24'(bad), 24'h0);
        cfg_en = 4'hd;
        cfg_ben = 1'b1;
        cfg_we = 1'b1;
        @(negedge clock);
        cfg_we = 1'b0;
        exp_en = 4'hd;
        $display("test combined select done");
        host_mode = 1'b1;
        req.fetch = 1'b1;
        go(emsd_pkg::EMSD_PM, 1'b0, 14'h2abc, 1'b0);
        chk(24'({err, seen, 4'(lat)}), 24'h101);
        req.fetch = 1'b0;
        go(emsd_pkg::EMSD_DM, 1'b0, 14'h1abd, 1'b1);
        chk(24'(xseen), 24'h000001);
        host_mode = 1'b0;
        $display("test host mode done");
        grant = 1'b1;
        repeat (3) @(negedge clock);
        chk(24'({core_ready, pm_n, dm_n, bm_n, io_n, cms_n}), 24'h1f);
        grant = 1'b0;
        go(emsd_pkg::EMSD_DM, 1'b0, 14'h1abd, 1'b1);
        chk(24'(lat), 24'h3);
        $display("test bus grant done");
        print_verdict();
    end

    // The whole sequence needs well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge clock);
        errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
